// ==== bench/ccfg_clock_model.sv ====
`timescale 1ns/1ps
module ccfg_clock_model #(
    parameter int INT_HALF_NS = 200,
    parameter int EXT_HALF_NS = 300,
    parameter int LOOP_HALF_NS = 150
) (
    output logic intRefPin,
    output logic extRefPin,
    output logic loopPin
);
    // ------------------------------------------------------------
    // Free-running sources
    // ------------------------------------------------------------
    // Offset of 13 ns keeps every pin edge away from the clk edges,
    // and all rates stay well under a quarter of the system clock.
    initial begin
        intRefPin = 1'b0;
        #13;
        forever #(INT_HALF_NS) intRefPin = ~intRefPin;
    end

    initial begin
        extRefPin = 1'b0;
        #13;
        forever #(EXT_HALF_NS) extRefPin = ~extRefPin;
    end

    initial begin
        loopPin = 1'b0;
        #13;
        forever #(LOOP_HALF_NS) loopPin = ~loopPin;
    end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb
    import ccfg_pkg::*;
;
    logic clk, resetn, wbCyc, wbStb, wbWe, wbAck;
    logic [ADDR_W-1:0] wbAdr;
    logic [3:0] wbSel;
    logic [DATA_W-1:0] wbDatI, wbDatO;
    logic intRefPin, extRefPin, loopPin, stopMode, backgroundDebug;
    logic internalRefClockOut, externalRefClockOut, generatorOutTick;
    logic busTick, loopRefTick, loopEnable, watched;
    logic [15:0] loopMultiplier;
    ccfg_osc_type oscCtrl;
    logic [8:0] refTrimCode;
    int failures = 0;
    int nTests = 0;
    int cycles = 0;
    int which = 0;

    ccfg_clock_model model (.intRefPin(intRefPin), .extRefPin(extRefPin),
        .loopPin(loopPin));

    ccfg_core dut (.clk(clk), .resetn(resetn), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
        .intRefPin(intRefPin), .extRefPin(extRefPin), .loopPin(loopPin),
        .stopMode(stopMode), .backgroundDebug(backgroundDebug),
        .internalRefClockOut(internalRefClockOut),
        .externalRefClockOut(externalRefClockOut),
        .generatorOutTick(generatorOutTick), .busTick(busTick),
        .loopRefTick(loopRefTick), .loopEnable(loopEnable),
        .loopMultiplier(loopMultiplier), .oscCtrl(oscCtrl),
        .refTrimCode(refTrimCode));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always_comb begin
        case (which)
            0: watched = generatorOutTick;
            1: watched = busTick;
            default: watched = loopRefTick;
        endcase
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (failures == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [ADDR_W-1:0] adr,
            input logic [7:0] dat, output logic [31:0] rd);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hf;
        wbDatI <= {24'h0, dat};
        do @(posedge clk); while (wbAck !== 1'b1);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] adr,
            input logic [7:0] exp);
        logic [31:0] d;
        wb(1'b0, adr, 8'h00, d);
        check(what, d, {24'h0, exp});
    endtask

    // Cycles between two ticks, after the new setting has landed
    task automatic gap(input int w, output int n);
        which = w;
        repeat (3) begin
            @(posedge clk);
            while (watched !== 1'b1) @(posedge clk);
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (watched !== 1'b1);
    endtask

    task automatic rises(input int w, output int n);
        logic prev, cur;
        n = 0;
        // First sample already reflects the new gate setting
        @(posedge clk);
        prev = w ? externalRefClockOut : internalRefClockOut;
        repeat (96) begin
            @(posedge clk);
            cur = w ? externalRefClockOut : internalRefClockOut;
            if (cur === 1'b1 && prev === 1'b0) n++;
            prev = cur;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rdchk("control one", OFF_CTRL1, 8'h04);
        rdchk("control two", OFF_CTRL2, 8'h40);
        rdchk("trim", OFF_TRIM, 8'h80);
        rdchk("status", OFF_STATUS, 8'h10);
        check("multiplier", loopMultiplier, 32'h400);
        check("trim code", refTrimCode, {8'h80, 1'b0});
    endtask

    task automatic test_regs();
        logic [7:0] val[3] = '{8'h34, 8'h20, 8'h14};
        logic [2:0] osc[3] = '{3'h7, 3'h4, 3'h3};
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CTRL2, val[i]);
            check("osc control", oscCtrl, osc[i]);
            rdchk("control two back", OFF_CTRL2, val[i]);
        end
        wr(OFF_TRIM, 8'h3c);
        wr(OFF_STATUS, 8'h01);
        check("trim code", refTrimCode, {8'h3c, 1'b1});
        rdchk("fine trim", OFF_STATUS, 8'h11);
        wr(8'h10, 8'hff);
        rdchk("unmapped", 8'h10, 8'h00);
    endtask

    task automatic test_source();
        int n;
        int srcGap[4] = '{6, 8, 12, 6};
        wr(OFF_CTRL2, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_CTRL1, {c[1:0], 6'h04});
            gap(0, n);
            check("source gap", n, srcGap[c]);
            rdchk("source status", OFF_STATUS,
                {3'h0, 1'b1, (c == 3) ? 2'h0 : c[1:0], 2'h1});
        end
        wr(OFF_CTRL1, 8'h44);
        for (int b = 0; b < 4; b++) begin
            wr(OFF_CTRL2, {b[1:0], 6'h00});
            gap(0, n);
            check("bus divider", n, 8 << b);
            gap(1, n);
            check("bus tick", n, 16 << b);
        end
    endtask

    task automatic test_refdiv();
        int n;
        int codes[3] = '{0, 3, 7};
        // Divider codes 0, 3 and 7 each leave the divided reference outside the legal band
        foreach (codes[i]) begin
            wr(OFF_CTRL1, {2'h0, codes[i][2:0], 3'h4});
            gap(2, n);
            check("ref divider", n, 8 << codes[i]);
        end
        wr(OFF_CTRL1, 8'h08);
        gap(2, n);
        check("external ref", n, 24);
        rdchk("ref status", OFF_STATUS, 8'h01);
    endtask

    task automatic test_outputs();
        int n;
        wr(OFF_CTRL1, 8'h06);
        rises(0, n);
        check("int out on", n, 12);
        wr(OFF_CTRL1, 8'h04);
        rises(0, n);
        check("int out off", n, 0);
        wr(OFF_CTRL2, 8'h02);
        rises(1, n);
        check("ext out on", n, 8);
        wr(OFF_CTRL2, 8'h00);
        rises(1, n);
        check("ext out off", n, 0);
    endtask

    task automatic test_stop();
        int n;
        wr(OFF_CTRL1, 8'h05);
        wr(OFF_CTRL2, 8'h01);
        stopMode <= 1'b1;
        repeat (8) @(posedge clk);
        rises(0, n);
        check("int kept by mode", n, 12);
        rises(1, n);
        check("ext dropped by mode", n, 0);
        wr(OFF_CTRL1, 8'h07);
        wr(OFF_CTRL2, 8'h03);
        rises(0, n);
        check("int kept in stop", n, 12);
        rises(1, n);
        check("ext kept in stop", n, 8);
        wr(OFF_CTRL1, 8'h06);
        wr(OFF_CTRL2, 8'h02);
        repeat (8) @(posedge clk);
        rises(0, n);
        check("int off in stop", n, 0);
        rises(1, n);
        check("ext off in stop", n, 0);
        stopMode <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic test_lowpower();
        int n;
        wr(OFF_CTRL1, 8'h44);
        wr(OFF_CTRL2, 8'h08);
        gap(0, n);
        check("loop off bypass", loopEnable, 1'b0);
        backgroundDebug <= 1'b1;
        repeat (3) @(posedge clk);
        check("loop on debug", loopEnable, 1'b1);
        backgroundDebug <= 1'b0;
        wr(OFF_CTRL2, 8'h00);
        repeat (3) @(posedge clk);
        check("loop on no lp", loopEnable, 1'b1);
        wr(OFF_CTRL1, 8'h04);
        wr(OFF_CTRL2, 8'h08);
        gap(0, n);
        check("loop on engaged", loopEnable, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = '0;
        wbSel = 4'h0;
        wbDatI = '0;
        stopMode = 1'b0;
        backgroundDebug = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        test_reset();
        test_regs();
        test_source();
        test_refdiv();
        test_outputs();
        test_stop();
        test_lowpower();
        final_report();
    end
endmodule

// ==== core/ccfg_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Source field picks loop, internal, external; reserved=loop
// - Source codes: 00 loop, 01 internal, 10 external
// - Reference divider divides by two to code
// - Reference select bit: internal set, external clear
// - Internal reference output gated by enable bit
// - Internal reference kept in stop when allowed
// - Bus divider divides by 1,2,4,8; resets 01
// - Range bit drives oscillator high range
// - Gain bit drives oscillator high gain
// - Low power bit stops loop in bypass
// - Oscillator request bit picks crystal or clock
// - External reference output gated by enable bit
// - External reference kept in stop when allowed
// - Eight-bit binary weighted trim lengthens period upward
// - Fine trim bit extends trim below step
// - Fine trim set lengthens, clear shortens period
// - Loop locks at 1024 times divided reference
// - Bus clock runs at half output rate
module ccfg_core
    import ccfg_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [ADDR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [DATA_W-1:0] wbDatI,
    output logic [DATA_W-1:0] wbDatO,
    output logic wbAck,
    input wire logic intRefPin,
    input wire logic extRefPin,
    input wire logic loopPin,
    input wire logic stopMode,
    input wire logic backgroundDebug,
    output logic internalRefClockOut,
    output logic externalRefClockOut,
    output logic generatorOutTick,
    output logic busTick,
    output logic loopRefTick,
    output logic loopEnable,
    output logic [15:0] loopMultiplier,
    output ccfg_osc_type oscCtrl,
    output logic [8:0] refTrimCode
);
    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] trim_reg;
    logic fine_reg;
    logic ack_reg;
    logic [DATA_W-1:0] rdata_reg;
    ccfg_src_type effSrc_reg;
    logic [1:0] effBdiv_reg;
    logic effRefSel_reg;
    logic [2:0] effRdiv_reg;
    logic [2:0] genCnt_reg;
    logic [6:0] refCnt_reg;
    logic busPhase_reg;
    logic wasIntMode_reg;
    logic wasExtMode_reg;
    logic intOut_reg;
    logic extOut_reg;
    logic genOut_reg;
    logic busOut_reg;
    logic refOut_reg;
    logic loopEn_reg;
    ccfg_tick_type tick;
    ccfg_tick_type level;
    logic [2:0] pins;
    ccfg_src_type reqSrc;
    logic selTick;
    logic genTick;
    logic busTickNow;
    logic refSelTick;
    logic refTick;
    logic [2:0] genMask;
    logic [6:0] refMask;
    logic intGate;
    logic extGate;
    logic bypassNow;
    logic wrAcc;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic ccfg_src_type srcOf(input logic [1:0] code);
        if (code == SRC_INT) begin
            return SRC_INT;
        end else if (code == SRC_EXT) begin
            return SRC_EXT;
        end
        return SRC_LOOP;
    endfunction

    function automatic logic [6:0] powMask(input logic [2:0] code);
        return 7'((8'h01 << code) - 8'h01);
    endfunction

    // ------------------------------------------------------------
    // Pin capture
    // ------------------------------------------------------------
    assign pins = {intRefPin, extRefPin, loopPin};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            ccfg_pin_sync u_sync (
                .clk(clk),
                .resetn(resetn),
                .pinIn(pins[i]),
                .level(level[i]),
                .riseTick(tick[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    assign wrAcc = wbCyc && wbStb && wbWe && !ack_reg && wbSel[0];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wbCyc && wbStb && !ack_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl1_reg <= CTRL1_RESET;
            ctrl2_reg <= CTRL2_RESET;
            trim_reg <= TRIM_RESET;
            fine_reg <= FINE_RESET;
        end else if (wrAcc) begin
            case (wbAdr)
                OFF_CTRL1: ctrl1_reg <= wbDatI[7:0];
                OFF_CTRL2: ctrl2_reg <= wbDatI[7:0];
                OFF_TRIM: trim_reg <= wbDatI[7:0];
                OFF_STATUS: fine_reg <= wbDatI[FINE_TRIM_BIT_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else if (wbCyc && wbStb && !wbWe && !ack_reg) begin
            rdata_reg <= '0;
            case (wbAdr)
                OFF_CTRL1: rdata_reg[7:0] <= ctrl1_reg;
                OFF_CTRL2: rdata_reg[7:0] <= ctrl2_reg;
                OFF_TRIM: rdata_reg[7:0] <= trim_reg;
                OFF_STATUS: begin
                    rdata_reg[STREF_BIT] <= effRefSel_reg;
                    rdata_reg[STSRC_HI:STSRC_LO] <= effSrc_reg;
                    rdata_reg[FINE_TRIM_BIT_BIT] <= fine_reg;
                end
                default: ;
            endcase
        end
    end

    assign wbAck = ack_reg;
    assign wbDatO = rdata_reg;

    // ------------------------------------------------------------
    // Source selection and bus divider
    // ------------------------------------------------------------
    assign reqSrc = srcOf(ctrl1_reg[SRC_HI:SRC_LO]);

    always_comb begin
        case (effSrc_reg)
            SRC_INT: selTick = tick.intRef;
            SRC_EXT: selTick = tick.extRef;
            default: selTick = tick.loop;
        endcase
    end

    assign genMask = 3'(powMask({1'b0, effBdiv_reg}));
    assign genTick = selTick && ((genCnt_reg & genMask) == genMask);

    // New source and divider are taken only between output periods
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            genCnt_reg <= '0;
            effSrc_reg <= SRC_LOOP;
            effBdiv_reg <= CTRL2_RESET[BUS_DIVIDER_HI:BUS_DIVIDER_LO];
        end else if (genTick || (genCnt_reg == '0 && !selTick)) begin
            genCnt_reg <= '0;
            effSrc_reg <= reqSrc;
            effBdiv_reg <= ctrl2_reg[BUS_DIVIDER_HI:BUS_DIVIDER_LO];
        end else if (selTick) begin
            genCnt_reg <= genCnt_reg + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busPhase_reg <= 1'b0;
        end else if (genTick) begin
            busPhase_reg <= !busPhase_reg;
        end
    end

    assign busTickNow = genTick && busPhase_reg;

    // ------------------------------------------------------------
    // Loop reference select and divider
    // ------------------------------------------------------------
    assign refSelTick = effRefSel_reg ? tick.intRef : tick.extRef;
    assign refMask = powMask(effRdiv_reg);
    assign refTick = refSelTick && ((refCnt_reg & refMask) == refMask);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            refCnt_reg <= '0;
            effRefSel_reg <= CTRL1_RESET[IREFSEL_BIT];
            effRdiv_reg <= CTRL1_RESET[REFERENCE_DIVIDER_HI:REFERENCE_DIVIDER_LO];
        end else if (refTick || (refCnt_reg == '0 && !refSelTick)) begin
            refCnt_reg <= '0;
            effRefSel_reg <= ctrl1_reg[IREFSEL_BIT];
            effRdiv_reg <= ctrl1_reg[REFERENCE_DIVIDER_HI:REFERENCE_DIVIDER_LO];
        end else if (refSelTick) begin
            refCnt_reg <= refCnt_reg + 7'h01;
        end
    end

    assign loopMultiplier = 16'(LOOP_MULT);

    // ------------------------------------------------------------
    // Stop handling and reference outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wasIntMode_reg <= 1'b0;
            wasExtMode_reg <= 1'b0;
        end else begin
            if (!stopMode) begin
                wasIntMode_reg <= (effSrc_reg == SRC_INT) ||
                    (effSrc_reg == SRC_LOOP && effRefSel_reg);
                wasExtMode_reg <= (effSrc_reg == SRC_EXT) ||
                    (effSrc_reg == SRC_LOOP && !effRefSel_reg);
            end
        end
    end

    assign intGate = stopMode ?
        (ctrl1_reg[IRKEEP_BIT] &&
         (ctrl1_reg[IROUT_BIT] || wasIntMode_reg)) :
        ctrl1_reg[IROUT_BIT];
    assign extGate = stopMode ?
        (ctrl2_reg[ERKEEP_BIT] &&
         (ctrl2_reg[EROUT_BIT] || wasExtMode_reg)) :
        ctrl2_reg[EROUT_BIT];

    assign bypassNow = effSrc_reg != SRC_LOOP;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            intOut_reg <= 1'b0;
            extOut_reg <= 1'b0;
            genOut_reg <= 1'b0;
            busOut_reg <= 1'b0;
            refOut_reg <= 1'b0;
            loopEn_reg <= 1'b0;
        end else begin
            intOut_reg <= level.intRef && intGate;
            extOut_reg <= level.extRef && extGate;
            genOut_reg <= genTick && !stopMode;
            busOut_reg <= busTickNow && !stopMode;
            refOut_reg <= refTick && !stopMode;
            loopEn_reg <= !stopMode && !(bypassNow &&
                ctrl2_reg[LP_BIT] && !backgroundDebug);
        end
    end

    assign internalRefClockOut = intOut_reg;
    assign externalRefClockOut = extOut_reg;
    assign generatorOutTick = genOut_reg;
    assign busTick = busOut_reg;
    assign loopRefTick = refOut_reg;
    assign loopEnable = loopEn_reg;
    assign oscCtrl.highRange = ctrl2_reg[RANGE_BIT];
    assign oscCtrl.highGain = ctrl2_reg[GAIN_BIT];
    assign oscCtrl.oscRequest = ctrl2_reg[OSCREQ_BIT];
    assign refTrimCode = {trim_reg, fine_reg};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_src_reserved: assert property (effSrc_reg != SRC_RSVD)
        else $error("reserved source became effective");
    a_src_int: assert property ((effSrc_reg == SRC_INT) |->
        (selTick == tick.intRef))
        else $error("internal bypass does not follow internal ticks");
    a_ref_wrap: assert property (refTick && !stopMode |=>
        loopRefTick && refCnt_reg == '0)
        else $error("reference divider did not wrap");
    a_ref_select: assert property ($stable(effRefSel_reg) && effRefSel_reg
        |-> refSelTick == tick.intRef)
        else $error("loop reference not internal");
    a_int_gate: assert property (!intGate |=> !internalRefClockOut)
        else $error("internal reference leaked");
    a_int_stop: assert property (stopMode && !ctrl1_reg[IRKEEP_BIT]
        |=> !internalRefClockOut)
        else $error("internal reference ran in stop");
    a_ext_stop: assert property (stopMode && !ctrl2_reg[ERKEEP_BIT]
        |=> !externalRefClockOut)
        else $error("external reference ran in stop");
    a_bus_divider_space: assert property (genTick && effBdiv_reg != 2'h0
        |=> !genTick)
        else $error("divided output too fast");
    a_loop_off: assert property (bypassNow && ctrl2_reg[LP_BIT] &&
        !backgroundDebug |=> !loopEnable)
        else $error("loop left on in low power bypass");
    a_bus_half: assert property (busTick |-> generatorOutTick)
        else $error("bus tick off the output grid");

    c_int_bypass: cover property (effSrc_reg == SRC_INT ##1 genTick);
    c_ext_bypass: cover property (effSrc_reg == SRC_EXT ##1 busTickNow);
    c_stop_keep: cover property (stopMode && internalRefClockOut);
    c_ref_div: cover property (effRdiv_reg == 3'h7 && refTick);
endmodule

// ==== core/ccfg_pin_sync.sv ====
`timescale 1ns/1ps
module ccfg_pin_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pinIn,
    output logic level,
    output logic riseTick
);
    logic meta_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic level_reg;

    // ------------------------------------------------------------
    // Three stage capture, level moves once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            meta_reg <= pinIn;
            sync2_reg <= meta_reg;
            sync3_reg <= sync2_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_reg <= 1'b0;
        end else if (sync2_reg == sync3_reg) begin
            level_reg <= sync3_reg;
        end
    end

    assign level = level_reg;
    assign riseTick = (sync2_reg == sync3_reg) && sync3_reg && !level_reg;
endmodule

// ==== core/ccfg_pkg.sv ====
package ccfg_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL2 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_TRIM = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;

    localparam logic [7:0] CTRL1_RESET = 8'h04;
    localparam logic [7:0] CTRL2_RESET = 8'h40;
    localparam logic [7:0] TRIM_RESET = 8'h80;
    localparam logic FINE_RESET = 1'b0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 6;
    localparam int REFERENCE_DIVIDER_HI = 5;
    localparam int REFERENCE_DIVIDER_LO = 3;
    localparam int IREFSEL_BIT = 2;
    localparam int IROUT_BIT = 1;
    localparam int IRKEEP_BIT = 0;
    localparam int BUS_DIVIDER_HI = 7;
    localparam int BUS_DIVIDER_LO = 6;
    localparam int RANGE_BIT = 5;
    localparam int GAIN_BIT = 4;
    localparam int LP_BIT = 3;
    localparam int OSCREQ_BIT = 2;
    localparam int EROUT_BIT = 1;
    localparam int ERKEEP_BIT = 0;
    localparam int STREF_BIT = 4;
    localparam int STSRC_HI = 3;
    localparam int STSRC_LO = 2;
    localparam int FINE_TRIM_BIT_BIT = 0;

    // ------------------------------------------------------------
    // Encodings and figures
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_LOOP = 2'h0,
        SRC_INT = 2'h1,
        SRC_EXT = 2'h2,
        SRC_RSVD = 2'h3
    } ccfg_src_type;

    localparam int LOOP_MULT = 1024;
    localparam int REF_MIN_HZ = 31250;
    localparam real REF_MAX_HZ = 39062.5;
    localparam int CLK_HZ = 20000000;
    localparam int REFERENCE_DIVIDER_MAX_CNT = 127;
    localparam int BUS_DIVIDER_MAX_CNT = 7;

    typedef struct packed {
        logic highRange;
        logic highGain;
        logic oscRequest;
    } ccfg_osc_type;

    typedef struct packed {
        logic intRef;
        logic extRef;
        logic loop;
    } ccfg_tick_type;

endpackage
